// >>> tmc_timer.sv
// Operation
// RQ1 - sixteen bit counter counts up only
// RQ2 - whole counter read as one coherent word
// RQ3 - counter readable always, writable only special
// RQ4 - counter write leaves prescaler phase untouched
// RQ5 - run enable bit seven stops timer
// RQ6 - divide-by-64 tick absent while timer inactive
// RQ7 - halt in wait bit six stops timer
// RQ8 - halt in wait also stops accumulator tick
// RQ9 - counter steps one per tick, wraps
`timescale 1ns/1ps
`include "tmc_params.svh"

module tmc_timer #(
  parameter int PRESC_W = 8,
  parameter logic [PRESC_W-1:0] PRESC_LAST = '0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire tmc_pkg::tmc_addr_t addr,
  input wire tmc_pkg::tmc_data_t wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output tmc_pkg::tmc_data_t rdata_q,
  // chip mode inputs
  input wire logic special_mode,
  input wire logic wait_mode,
  // status and ticks
  output logic timer_active_q,
  output logic pacc_tick_q
);
  import tmc_pkg::*;

  tmc_ctrl_t ctrl_q, ctrl_d;
  tmc_count_t cnt_q, cnt_d;
  tmc_data_t rdata_d;
  logic active_d;
  logic cnt_tick;
  logic div64_tick;
  logic wr_ctrl, wr_hi, wr_lo, rd_hi;

  assign wr_ctrl = wr_stb && (addr == `TMC_OFS_CTRL);
  assign wr_hi = wr_stb && (addr == `TMC_OFS_CNT_HI);
  assign wr_lo = wr_stb && (addr == `TMC_OFS_CNT_LO);
  assign rd_hi = rd_stb && (addr == `TMC_OFS_CNT_HI);

  // control register
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d.timer_run_enable = wdata[`TMC_BIT_RUN];
      ctrl_d.halt_in_wait = wdata[`TMC_BIT_HALTW];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= `TMC_CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // run gating: one term drives both the counter and the accumulator tick,
  // so the two always stop and restart together
  always_comb begin
    active_d = ctrl_q.timer_run_enable; // RQ5
    if (wait_mode && ctrl_q.halt_in_wait) begin
      active_d = 1'b0; // RQ7 RQ8
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      timer_active_q <= 1'b0;
    end else begin
      timer_active_q <= active_d;
    end
  end

  // the prescaler sees the same next value that timer_active_q takes, so its
  // registered ticks only ever appear while timer_active_q is high
  tmc_prescaler #(
    .PRESC_W(PRESC_W),
    .PRESC_LAST(PRESC_LAST)
  ) u_presc (
    .mclk(mclk),
    .rst(rst),
    .active(active_d),
    .cnt_tick_q(cnt_tick),
    .div64_tick_q(div64_tick)
  );

  always_comb begin
    pacc_tick_q = div64_tick; // RQ6 RQ8
  end

  // main counter; a special mode write wins over a tick in the same cycle
  always_comb begin
    cnt_d = cnt_q;
    if (cnt_tick && timer_active_q) begin
      cnt_d = cnt_q + `TMC_CNT_STEP; // RQ1 RQ9
    end
    if (special_mode) begin // RQ3
      // the prescaler keeps its phase, so the next interval may be shorter than a full one, never longer
      if (wr_hi) begin
        cnt_d = wdata; // RQ4
      end else if (wr_lo) begin
        cnt_d = {cnt_q[15:8], wdata[7:0]}; // RQ4
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_q <= `TMC_CNT_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // read data stands only in the cycle after the strobe
  always_comb begin
    rdata_d = `TMC_RDATA_RST;
    if (rd_stb) begin
      case (addr)
        `TMC_OFS_CNT_HI: begin
          rdata_d = cnt_q; // RQ2 RQ3
        end
        `TMC_OFS_CNT_LO: begin
          rdata_d = {`TMC_BYTE_ZERO, cnt_q[7:0]}; // RQ3
        end
        `TMC_OFS_CTRL: begin
          rdata_d = {`TMC_BYTE_ZERO, ctrl_q.timer_run_enable, ctrl_q.halt_in_wait, `TMC_CTRL_PAD};
        end
        default: begin
          rdata_d = `TMC_RDATA_RST;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= `TMC_RDATA_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // checks

  sequence tmc_halt_req_s;
    wait_mode && ctrl_q.halt_in_wait;
  endsequence

  sequence tmc_stopped_s;
    !timer_active_q && !pacc_tick_q;
  endsequence

  sequence tmc_norm_write_s;
    (wr_hi || wr_lo) && !special_mode;
  endsequence

  cnt_step_a: assert property (@(posedge mclk) disable iff (rst) // RQ1
    cnt_tick && timer_active_q && !(special_mode && (wr_hi || wr_lo))
    |=> cnt_q == tmc_count_t'($past(cnt_q) + `TMC_CNT_STEP))
    else $error("counter did not step by one");

  // only a write in the wrap cycle may mask the wrap, special mode alone does not
  cnt_wrap_a: assert property (@(posedge mclk) disable iff (rst) // RQ9
    cnt_tick && timer_active_q && (cnt_q == `TMC_CNT_MAX) && !(special_mode && (wr_hi || wr_lo))
    |=> cnt_q == `TMC_CNT_RST)
    else $error("counter did not wrap to zero");

  cnt_hold_a: assert property (@(posedge mclk) disable iff (rst) // RQ5
    !timer_active_q && !special_mode |=> $stable(cnt_q))
    else $error("counter moved while stopped");

  up_only_a: assert property (@(posedge mclk) disable iff (rst) // RQ1
    !special_mode |=> (cnt_q == $past(cnt_q)) || (cnt_q == tmc_count_t'($past(cnt_q) + `TMC_CNT_STEP)))
    else $error("counter moved other than one step up");

  word_read_a: assert property (@(posedge mclk) disable iff (rst) // RQ2
    rd_hi |=> rdata_q == $past(cnt_q))
    else $error("word read not coherent");

  low_read_a: assert property (@(posedge mclk) disable iff (rst) // RQ3
    rd_stb && (addr == `TMC_OFS_CNT_LO) |=> rdata_q == {`TMC_BYTE_ZERO, $past(cnt_q[7:0])})
    else $error("low byte read wrong");

  read_once_a: assert property (@(posedge mclk) disable iff (rst) // RQ3
    !rd_stb |=> rdata_q == `TMC_RDATA_RST)
    else $error("read data outside its cycle");

  norm_write_a: assert property (@(posedge mclk) disable iff (rst) // RQ3
    tmc_norm_write_s |=> (cnt_q == $past(cnt_q)) || (cnt_q == tmc_count_t'($past(cnt_q) + `TMC_CNT_STEP)))
    else $error("counter write took effect in normal mode");

  spec_write_a: assert property (@(posedge mclk) disable iff (rst) // RQ4
    wr_hi && special_mode |=> cnt_q == $past(wdata))
    else $error("special mode write lost");

  spec_low_a: assert property (@(posedge mclk) disable iff (rst) // RQ4
    wr_lo && special_mode |=> cnt_q == {$past(cnt_q[15:8]), $past(wdata[7:0])})
    else $error("special mode low byte write lost");

  run_bit_a: assert property (@(posedge mclk) disable iff (rst) // RQ5
    wr_ctrl && !wdata[`TMC_BIT_RUN] |=> ##1 tmc_stopped_s)
    else $error("run enable clear did not stop timer");

  run_clear_a: assert property (@(posedge mclk) disable iff (rst) // RQ5
    !ctrl_q.timer_run_enable |=> tmc_stopped_s)
    else $error("timer ran with run enable clear");

  halt_wait_a: assert property (@(posedge mclk) disable iff (rst) // RQ7 RQ8
    tmc_halt_req_s |=> tmc_stopped_s)
    else $error("timer ran in wait with halt set");

  wait_run_a: assert property (@(posedge mclk) disable iff (rst) // RQ7
    wait_mode && ctrl_q.timer_run_enable && !ctrl_q.halt_in_wait |=> timer_active_q)
    else $error("timer stopped in wait with halt clear");

  tick_gate_a: assert property (@(posedge mclk) disable iff (rst) // RQ6
    pacc_tick_q |-> timer_active_q)
    else $error("accumulator tick while inactive");
endmodule

// >>> tmc_params.svh
`ifndef TMC_PARAMS_SVH
`define TMC_PARAMS_SVH

// register offsets in the module window
`define TMC_OFS_CNT_HI 8'h04
`define TMC_OFS_CNT_LO 8'h05
`define TMC_OFS_CTRL 8'h06

// control register field positions
`define TMC_BIT_RUN 7
`define TMC_BIT_HALTW 6

// reset values
`define TMC_CTRL_RST 2'h0
`define TMC_CNT_RST 16'h0000
`define TMC_RDATA_RST 16'h0000
`define TMC_BYTE_ZERO 8'h00
`define TMC_CTRL_PAD 6'h00

// counts
`define TMC_CNT_STEP 16'h0001
`define TMC_CNT_MAX 16'hffff
`define TMC_DIV64_LAST 6'h3f
`define TMC_DIV64_RST 6'h00
`define TMC_DIV64_STEP 6'h01

`endif

// >>> tmc_pkg.sv
package tmc_pkg;
  typedef logic [15:0] tmc_count_t;
  typedef logic [15:0] tmc_data_t;
  typedef logic [7:0] tmc_addr_t;
  // control bits kept: run enable and halt in wait
  typedef struct packed {
    logic timer_run_enable;
    logic halt_in_wait;
  } tmc_ctrl_t;
endpackage

// >>> tmc_prescaler.sv
`timescale 1ns/1ps
`include "tmc_params.svh"

module tmc_prescaler #(
  parameter int PRESC_W = 8,
  parameter logic [PRESC_W-1:0] PRESC_LAST = '0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // gating from the control logic
  input wire logic active,
  // ticks
  output logic cnt_tick_q,
  output logic div64_tick_q
);
  import tmc_pkg::*;

  logic [PRESC_W-1:0] pre_q, pre_d;
  logic [5:0] d64_q, d64_d;
  logic cnt_tick_d, div64_tick_d;

  // both dividers freeze while inactive, so no tick of either kind appears
  always_comb begin
    pre_d = pre_q;
    d64_d = d64_q;
    cnt_tick_d = 1'b0;
    div64_tick_d = 1'b0;
    if (active) begin // RQ6
      if (pre_q == PRESC_LAST) begin
        pre_d = '0;
        cnt_tick_d = 1'b1;
      end else begin
        pre_d = pre_q + {{(PRESC_W-1){1'b0}}, 1'b1};
      end
      if (d64_q == `TMC_DIV64_LAST) begin
        d64_d = `TMC_DIV64_RST;
        div64_tick_d = 1'b1;
      end else begin
        d64_d = d64_q + `TMC_DIV64_STEP;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pre_q <= '0;
      d64_q <= `TMC_DIV64_RST;
      cnt_tick_q <= 1'b0;
      div64_tick_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      d64_q <= d64_d;
      cnt_tick_q <= cnt_tick_d;
      div64_tick_q <= div64_tick_d;
    end
  end

  div64_space_a: assert property (@(posedge mclk) disable iff (rst) // RQ6
    div64_tick_q |=> !div64_tick_q [*8])
    else $error("divide-by-64 ticks too close");

  div64_gate_a: assert property (@(posedge mclk) disable iff (rst) // RQ6
    !active |=> !div64_tick_q && !cnt_tick_q)
    else $error("tick produced while inactive");
endmodule

// >>> tmc_timer_test.sv
`timescale 1ns/1ps
module tmc_timer_test;
  import tmc_pkg::*;
  logic mclk, rst, wr_stb, rd_stb, special_mode, wait_mode;
  tmc_addr_t addr;
  tmc_data_t wdata, rdata_q, a, b, c;
  logic timer_active_q, pacc_tick_q;
  int err_total, tests_run, ticks, t0, i;

  tmc_timer uut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata_q(rdata_q), .special_mode(special_mode), .wait_mode(wait_mode),
    .timer_active_q(timer_active_q), .pacc_tick_q(pacc_tick_q));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // counted on the falling edge so the main sequence never races it
  always @(negedge mclk) begin
    if (pacc_tick_q === 1'b1) ticks++;
  end

  task automatic chk(input tmc_data_t got, input tmc_data_t exp);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask

  task automatic wr(input tmc_addr_t ad, input tmc_data_t d);
    @(posedge mclk);
    addr <= ad;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask

  // reads are taken every second edge, so a running counter steps by two
  task automatic rd(input tmc_addr_t ad, output tmc_data_t d);
    @(posedge mclk);
    addr <= ad;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    @(negedge mclk);
    d = rdata_q;
  endtask

  task automatic tick_win(input int n, input int exp);
    t0 = ticks;
    repeat (n) @(posedge mclk);
    chk(16'(ticks - t0), 16'(exp));
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #200us;
    err_total++;
    print_verdict;
  end

  initial begin
    {wr_stb, rd_stb, special_mode, wait_mode} = 4'h0;
    addr = 8'h00;
    wdata = 16'h0000;
    err_total = 0;
    tests_run = 0;
    ticks = 0;
    rst = 1'b1;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rd(8'h06, a); chk(a, 16'h0000);
    rd(8'h04, a); chk(a, 16'h0000);
    wr(8'h06, 16'h00ff);
    rd(8'h06, a); chk(a, 16'h00c0);
    chk({15'h0, timer_active_q}, 16'h0001);
    rd(8'h04, a);
    rd(8'h04, b); chk(b, a + 16'h0002);
    rd(8'h05, c);
    b = b + 16'h0002;
    chk(c, {8'h00, b[7:0]});
    // halted while waiting: no counting, no accumulator tick
    @(posedge mclk) wait_mode <= 1'b1;
    repeat (2) @(posedge mclk);
    chk({15'h0, timer_active_q}, 16'h0000);
    rd(8'h04, a);
    rd(8'h04, b); chk(b, a);
    tick_win(200, 0);
    wr(8'h06, 16'h0080);
    repeat (2) @(posedge mclk);
    chk({15'h0, timer_active_q}, 16'h0001);
    tick_win(640, 10);
    @(posedge mclk) wait_mode <= 1'b0;
    wr(8'h06, 16'h0000);
    rd(8'h04, a);
    wr(8'h04, 16'h1234);
    rd(8'h04, b); chk(b, a);
    chk({15'h0, timer_active_q}, 16'h0000);
    tick_win(200, 0);
    @(posedge mclk) special_mode <= 1'b1;
    wr(8'h04, 16'hfffd);
    rd(8'h04, b); chk(b, 16'hfffd);
    wr(8'h05, 16'h0077);
    rd(8'h04, b); chk(b, 16'hff77);
    // write lands while running, then the reads walk across the wrap
    wr(8'h06, 16'h0080);
    wr(8'h04, 16'hfffd);
    rd(8'h04, a);
    for (i = 0; i < 3; i++) begin
      rd(8'h04, b); chk(b, a + 16'h0002);
      a = b;
    end
    chk({15'h0, a < 16'h0010}, 16'h0001);
    rd(8'h07, a); chk(a, 16'h0000);
    // read data must be gone one cycle later
    @(negedge mclk) chk(rdata_q, 16'h0000);
    // reset in mid-run clears the counter and stops the timer
    @(posedge mclk) rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    chk({15'h0, timer_active_q}, 16'h0000);
    rd(8'h06, a); chk(a, 16'h0000);
    rd(8'h04, a); chk(a, 16'h0000);
    print_verdict;
  end
endmodule
